/* hw/dpc_core.sv */
// Purpose: command decoder and wiper register transfers of a two-string digipot
// Assumes: link side hands one 16-bit word per valid/ready handshake
// Notes: link clock must keep running until the word is acknowledged
`timescale 1ns/10ps
`include "dpc_cfg.svh"
module dpc_core
  import dpc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  input wire logic link_srst_in,
  input wire dpc_word_t cmd_word_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  output logic [7:0] read_data_out,
  output logic read_valid_out,
  input wire logic load_wiper_strobe_n_in,
  input wire logic reset_n_in,
  input wire logic independent_mode_pin_in,
  output dpc_pot_t pot_out,
  output logic busy_out
);
  localparam logic [`DPC_CNT_W-1:0] RLD_LAST = `DPC_CNT_W'(`DPC_RLD_CYCLES - 1);
  localparam dpc_core_t CORE_RST = '{
    state: ST_RLD,
    word: '0,
    wiper: {2{`DPC_WIPER_RST}},
    inreg: {2{`DPC_WIPER_RST}},
    nv: `DPC_NV_RST,
    ctrl: `DPC_CTRL_RST,
    shdn: '0,
    tsc: '0,
    bsc: '0,
    lin: 1'b0,
    req_seen: 1'b0,
    ack_tgl: 1'b0,
    rd_data: '0,
    ld_prev: 1'b1,
    rp_prev: 1'b1,
    pwr: 1'b1,
    cnt: '0
  };

  dpc_core_t r_reg;
  dpc_core_t r_next;
  dpc_link_t lr_reg;
  dpc_link_t lr_next;

  logic [3:0] pins_sync;
  logic independent_mode_pin_s;
  logic rst_pin_s;
  logic ld_pin_s;
  logic req_s;
  logic ack_s;
  logic ld_fall;
  logic rp_fall;
  logic req_new;
  logic hw_load;
  logic [1:0] mask;
  logic ch;
  logic wen;
  logic nve;
  logic d0;
  logic [1:0] we;
  logic [1:0][7:0] v;

  // link toggle and pins all enter through the same three-flop filter
  dpc_sync #(
    .W(4),
    .RST_VAL(`DPC_PIN_RST)
  ) u_pin_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in({independent_mode_pin_in, reset_n_in, load_wiper_strobe_n_in, lr_reg.req_tgl}),
    .q_out(pins_sync)
  );

  dpc_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_ack_sync (
    .clk_in(link_clk_in),
    .srst_in(link_srst_in),
    .d_in(r_reg.ack_tgl),
    .q_out(ack_s)
  );

  assign {independent_mode_pin_s, rst_pin_s, ld_pin_s, req_s} = pins_sync;

  always_comb begin
    r_next = r_reg;
    we = '0;
    v = r_reg.wiper;
    mask = dpc_chan_mask(r_reg.word.addr, r_reg.lin);
    ch = r_reg.lin & r_reg.word.addr[`DPC_ADDR_STR];
    wen = r_reg.ctrl[`DPC_CTRL_WUE];
    nve = r_reg.ctrl[`DPC_CTRL_NVE];
    d0 = r_reg.word.data[`DPC_DATA_D0];
    ld_fall = r_reg.ld_prev & ~ld_pin_s;
    rp_fall = r_reg.rp_prev & ~rst_pin_s;
    req_new = req_s != r_reg.req_seen;
    hw_load = 1'b0;
    r_next.ld_prev = ld_pin_s;
    r_next.rp_prev = rst_pin_s;
    r_next.lin = independent_mode_pin_s | r_reg.ctrl[`DPC_CTRL_LIN];
    unique case (r_reg.state)
      ST_IDLE: begin
        if (rp_fall) begin
          r_next.state = ST_RLD;
          r_next.cnt = '0;
          r_next.pwr = 1'b0;
          r_next.ctrl[`DPC_CTRL_BURST] = 1'b0;
        end else if (req_new) begin
          // word is held still by the link side until acknowledged
          r_next.word = lr_reg.word;
          r_next.req_seen = req_s;
          r_next.state = ST_EXEC;
        end else if (ld_fall) begin
          // pin load only while idle, so it never splits a command
          hw_load = 1'b1;
          we = {2{wen}};
          v = r_reg.inreg;
        end
      end
      ST_EXEC: begin
        r_next.state = ST_IDLE;
        r_next.ack_tgl = ~r_reg.ack_tgl;
        case (r_reg.word.code)
          `DPC_CMD_WR_WIPER: begin
            we = mask & {2{wen}};
            v = {2{r_reg.word.data}};
          end
          `DPC_CMD_STAGE: begin
            for (int i = 0; i < 2; i++) begin
              if (mask[i]) begin
                r_next.inreg[i] = r_reg.word.data;
              end
            end
          end
          `DPC_CMD_READ: begin
            unique case (r_reg.word.data[1:0])
              `DPC_RD_INPUT: r_next.rd_data = r_reg.inreg[ch];
              `DPC_RD_NV: r_next.rd_data = r_reg.nv[r_reg.word.addr[1:0]];
              `DPC_RD_CTRL: r_next.rd_data = {4'h0, r_reg.ctrl};
              `DPC_RD_WIPER: r_next.rd_data = r_reg.wiper[ch];
            endcase
          end
          `DPC_CMD_STEP: begin
            we = mask & {2{wen}};
            for (int i = 0; i < 2; i++) begin
              if (d0) begin
                v[i] = (r_reg.wiper[i] == `DPC_WIPER_MAX) ? r_reg.wiper[i] :
                       r_reg.wiper[i] + `DPC_WIPER_ONE;
              end else begin
                v[i] = (r_reg.wiper[i] == `DPC_WIPER_MIN) ? r_reg.wiper[i] :
                       r_reg.wiper[i] - `DPC_WIPER_ONE;
              end
            end
          end
          `DPC_CMD_SHIFT: begin
            we = mask & {2{wen}};
            for (int i = 0; i < 2; i++) begin
              if (!d0) begin
                v[i] = {1'b0, r_reg.wiper[i][7:1]};
              end else if (r_reg.wiper[i] == `DPC_WIPER_MIN) begin
                v[i] = `DPC_WIPER_ONE;
              end else if (r_reg.wiper[i][7]) begin
                v[i] = `DPC_WIPER_MAX;
              end else begin
                v[i] = {r_reg.wiper[i][6:0], 1'b0};
              end
            end
          end
          `DPC_CMD_LOAD: begin
            we = mask & {2{wen}};
            v = r_reg.inreg;
          end
          `DPC_CMD_NV_COPY: begin
            if (d0) begin
              if (nve) begin
                r_next.nv[{1'b0, ch}] = r_reg.wiper[ch];
              end
            end else begin
              // restore from memory stays allowed under wiper protection
              we[ch] = 1'b1;
              v[ch] = r_reg.nv[{1'b0, ch}];
            end
          end
          `DPC_CMD_NV_WR: begin
            if (nve) begin
              r_next.nv[r_reg.word.addr[1:0]] = r_reg.word.data;
            end
          end
          `DPC_CMD_SCALE: begin
            for (int i = 0; i < 2; i++) begin
              if (mask[i] && r_reg.word.data[`DPC_DATA_TOP]) begin
                r_next.tsc[i] = d0;
              end else if (mask[i]) begin
                r_next.bsc[i] = d0;
              end
            end
          end
          `DPC_CMD_SW_RESET: begin
            r_next.state = ST_RLD;
            r_next.cnt = '0;
            r_next.pwr = 1'b0;
            r_next.ctrl[`DPC_CTRL_BURST] = 1'b0;
          end
          `DPC_CMD_SHUTDOWN: begin
            for (int i = 0; i < 2; i++) begin
              if (mask[i]) begin
                r_next.shdn[i] = d0;
              end
            end
          end
          `DPC_CMD_CTRL_WR: begin
            r_next.ctrl = r_reg.word.data[3:0];
          end
          default: begin
          end
        endcase
      end
      ST_RLD: begin
        r_next.cnt = r_reg.cnt + `DPC_CNT_W'(1);
        if (r_reg.cnt == RLD_LAST) begin
          r_next.state = ST_IDLE;
          r_next.cnt = '0;
          r_next.pwr = 1'b0;
          for (int i = 0; i < 2; i++) begin
            // power-up in pot mode leaves the upper string at reset value
            if (!r_reg.pwr || independent_mode_pin_s || i == 0) begin
              r_next.wiper[i] = r_reg.nv[i];
              r_next.inreg[i] = r_reg.nv[i];
              r_next.tsc[i] = 1'b0;
              r_next.bsc[i] = 1'b0;
            end
          end
        end
      end
    endcase
    // a new wiper value leaves any scale position; input follows the wiper
    for (int i = 0; i < 2; i++) begin
      if (we[i]) begin
        r_next.wiper[i] = v[i];
        r_next.inreg[i] = v[i];
        r_next.tsc[i] = 1'b0;
        r_next.bsc[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pot_out = '{
    wiper: r_reg.wiper,
    shutdown: r_reg.shdn,
    top_scale: r_reg.tsc,
    bottom_scale: r_reg.bsc,
    linear_mode_bit: r_reg.lin,
    burst: r_reg.ctrl[`DPC_CTRL_BURST]
  };
  assign busy_out = r_reg.state != ST_IDLE;

  // link side: holds one word until the core toggles its acknowledge
  always_comb begin
    lr_next = lr_reg;
    lr_next.rd_valid = 1'b0;
    if (cmd_valid_in && !lr_reg.pending) begin
      lr_next.word = cmd_word_in;
      lr_next.req_tgl = ~lr_reg.req_tgl;
      lr_next.pending = 1'b1;
      lr_next.is_read = cmd_word_in.code == `DPC_CMD_READ;
    end else if (lr_reg.pending && ack_s != lr_reg.ack_seen) begin
      lr_next.ack_seen = ack_s;
      lr_next.pending = 1'b0;
      if (lr_reg.is_read) begin
        // core result is static until the next word, safe to take whole
        lr_next.rd_data = r_reg.rd_data;
        lr_next.rd_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (link_srst_in) begin
      lr_reg <= '0;
    end else begin
      lr_reg <= lr_next;
    end
  end

  assign cmd_ready_out = ~lr_reg.pending;
  assign read_data_out = lr_reg.rd_data;
  assign read_valid_out = lr_reg.rd_valid;

  sequence s_exec(logic [3:0] c);
    r_reg.state == ST_EXEC && r_reg.word.code == c;
  endsequence

  sequence s_rld_done;
    r_reg.state == ST_RLD && r_reg.cnt == RLD_LAST && !r_reg.pwr;
  endsequence

  AST_HW_LOAD_COPY:
  assert property (@(posedge clk_in) disable iff (srst_in)
    hw_load && wen |=> r_reg.wiper == $past(r_reg.inreg) && r_reg.state == ST_IDLE)
    else $error("pin load did not copy input registers");

  AST_LOAD_IGNORED_BUSY:
  assert property (@(posedge clk_in) disable iff (srst_in)
    ld_fall && r_reg.state == ST_RLD && r_reg.cnt != RLD_LAST |=> $stable(r_reg.wiper))
    else $error("pin load acted while busy");

  AST_STAGE_KEEPS_WIPER:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_exec(`DPC_CMD_STAGE) ##1 r_reg.state == ST_IDLE |-> $stable(r_reg.wiper))
    else $error("stage command moved a wiper");

  AST_SW_LOAD_ALL:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_exec(`DPC_CMD_LOAD) and (r_reg.lin && r_reg.word.addr[`DPC_ADDR_ALL] && wen)
    |=> r_reg.wiper == $past(r_reg.inreg))
    else $error("software load missed a channel");

  AST_MODE_OR:
  assert property (@(posedge clk_in) disable iff (srst_in)
    ##2 pot_out.linear_mode_bit == $past(independent_mode_pin_s | r_reg.ctrl[`DPC_CTRL_LIN], 1))
    else $error("mode is not pin or control bit");

  AST_WRITE_WIPER:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_exec(`DPC_CMD_WR_WIPER) and (!r_reg.lin && !r_reg.word.addr[`DPC_ADDR_STR] && wen)
    |=> r_reg.wiper[0] == $past(r_reg.word.data) && r_reg.inreg[0] == r_reg.wiper[0])
    else $error("write did not reach wiper");

  AST_READ_CTRL:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_exec(`DPC_CMD_READ) and (r_reg.word.data[1:0] == `DPC_RD_CTRL)
    |=> r_reg.rd_data == {4'h0, $past(r_reg.ctrl)})
    else $error("control readback wrong");

  AST_STEP_UP:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_exec(`DPC_CMD_STEP) and (d0 && wen && mask[0] && r_reg.wiper[0] != `DPC_WIPER_MAX)
    |=> r_reg.wiper[0] == $past(r_reg.wiper[0]) + `DPC_WIPER_ONE)
    else $error("increment wrong");

  AST_RELOAD:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_rld_done |=> r_reg.wiper == $past(r_reg.nv[1:0]) && !busy_out)
    else $error("reset did not reload wipers");

  AST_SCALE_KEEPS_WIPER:
  assert property (@(posedge clk_in) disable iff (srst_in)
    s_exec(`DPC_CMD_SCALE) |=> $stable(r_reg.wiper))
    else $error("scale command moved a wiper");

  AST_LINK_HOLD:
  assert property (@(posedge link_clk_in) disable iff (link_srst_in)
    lr_reg.pending && ack_s == lr_reg.ack_seen |=> $stable(lr_reg.word) && lr_reg.pending)
    else $error("link word changed while pending");
endmodule

/* hw/dpc_cfg.svh */
// Purpose: constants of the digipot command decoder (dpc)
// Assumes: 100 MHz core clock; 16-bit command words; two wiper channels
// Notes: the package holds the types, this header holds every number
`ifndef DPC_CFG_SVH
`define DPC_CFG_SVH

`define DPC_CMD_NOP 4'h0
`define DPC_CMD_WR_WIPER 4'h1
`define DPC_CMD_STAGE 4'h2
`define DPC_CMD_READ 4'h3
`define DPC_CMD_STEP 4'h4
`define DPC_CMD_SHIFT 4'h5
`define DPC_CMD_LOAD 4'h6
`define DPC_CMD_NV_COPY 4'h7
`define DPC_CMD_NV_WR 4'h8
`define DPC_CMD_SCALE 4'h9
`define DPC_CMD_SW_RESET 4'hb
`define DPC_CMD_SHUTDOWN 4'hc
`define DPC_CMD_CTRL_WR 4'hd

`define DPC_RD_INPUT 2'h0
`define DPC_RD_NV 2'h1
`define DPC_RD_CTRL 2'h2
`define DPC_RD_WIPER 2'h3

`define DPC_CTRL_WUE 0
`define DPC_CTRL_NVE 1
`define DPC_CTRL_LIN 2
`define DPC_CTRL_BURST 3
`define DPC_CTRL_RST 4'h3

`define DPC_ADDR_ALL 3
`define DPC_ADDR_STR 2
`define DPC_DATA_D0 0
`define DPC_DATA_TOP 7

`define DPC_WIPER_MIN 8'h00
`define DPC_WIPER_ONE 8'h01
`define DPC_WIPER_MAX 8'hff
`define DPC_WIPER_RST 8'h80
`define DPC_NV_RST 32'h0000_8080

`define DPC_CLK_MHZ 100
`define DPC_RESET_TIME_US 30
`define DPC_RLD_CYCLES (`DPC_RESET_TIME_US * `DPC_CLK_MHZ)
`define DPC_CNT_W 12

`define DPC_PIN_RST 4'h6

`endif

/* hw/dpc_pkg.sv */
// Purpose: types shared by the dpc design files
// Assumes: dpc_cfg.svh supplies every constant
// Notes: channel 0 is the lower string, channel 1 the upper string
`include "dpc_cfg.svh"
package dpc_pkg;

  typedef struct packed {
    logic [3:0] code;
    logic [3:0] addr;
    logic [7:0] data;
  } dpc_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_RLD = 3'h4
  } dpc_state_t;

  typedef struct packed {
    logic [1:0][7:0] wiper;
    logic [1:0] shutdown;
    logic [1:0] top_scale;
    logic [1:0] bottom_scale;
    logic linear_mode_bit;
    logic burst;
  } dpc_pot_t;

  typedef struct packed {
    dpc_state_t state;
    dpc_word_t word;
    logic [1:0][7:0] wiper;
    logic [1:0][7:0] inreg;
    logic [3:0][7:0] nv;
    logic [3:0] ctrl;
    logic [1:0] shdn;
    logic [1:0] tsc;
    logic [1:0] bsc;
    logic lin;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rd_data;
    logic ld_prev;
    logic rp_prev;
    logic pwr;
    logic [`DPC_CNT_W-1:0] cnt;
  } dpc_core_t;

  typedef struct packed {
    dpc_word_t word;
    logic req_tgl;
    logic pending;
    logic is_read;
    logic ack_seen;
    logic [7:0] rd_data;
    logic rd_valid;
  } dpc_link_t;

  // which wipers an address reaches; pot mode has only the lower string
  function automatic logic [1:0] dpc_chan_mask(input logic [3:0] addr, input logic lin);
    if (addr[`DPC_ADDR_ALL]) begin
      return lin ? 2'h3 : 2'h1;
    end
    if (lin) begin
      return addr[`DPC_ADDR_STR] ? 2'h2 : 2'h1;
    end
    return addr[`DPC_ADDR_STR] ? 2'h0 : 2'h1;
  endfunction

endpackage

/* hw/dpc_sync.sv */
// Purpose: three-flop synchroniser with agreement filter
// Assumes: inputs come from another clock domain or a pin
// Notes: output moves only once the second and third stages agree
`timescale 1ns/10ps
module dpc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t r_reg;
  sync_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_reg <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_out = r_reg.q;
endmodule

/* tb/dpc_host_model.sv */
// Purpose: host-side model that offers command words on the link
// Assumes: one word in flight; ready and read valid come from the decoder
// Notes: link clock runs only during link reset and within a transfer
`timescale 1ns/10ps
module dpc_host_model
  import dpc_pkg::*;
(
  input wire logic link_srst_in,
  input wire logic cmd_ready_in,
  input wire logic [7:0] read_data_in,
  input wire logic read_valid_in,
  output logic link_clk_out,
  output dpc_word_t cmd_word_out,
  output logic cmd_valid_out
);
  logic run;

  initial begin
    run = 1'h0;
    link_clk_out = 1'h0;
    cmd_valid_out = 1'h0;
    cmd_word_out = 16'h0000;
    #7;
    // halts only when low, so no half cycle is left pending
    forever begin
      #32;
      if (run || link_srst_in || link_clk_out) begin
        link_clk_out = ~link_clk_out;
      end
    end
  end

  task automatic send(input dpc_word_t w, output logic [7:0] rd, output logic rd_seen,
                      output logic acked);
    int n;
    n = 0;
    run = 1'h1;
    @(posedge link_clk_out);
    cmd_word_out <= w;
    cmd_valid_out <= 1'h1;
    // ready is registered: look at it mid-cycle, act on the next edge
    do begin
      @(negedge link_clk_out);
      n++;
    end while (cmd_ready_in !== 1'h1 && n < 1000);
    @(posedge link_clk_out);
    cmd_valid_out <= 1'h0;
    // released lines never keep showing the last word
    cmd_word_out <= ~w;
    do begin
      @(negedge link_clk_out);
      n++;
    end while (cmd_ready_in !== 1'h1 && n < 2000);
    rd_seen = read_valid_in;
    rd = read_data_in;
    acked = cmd_ready_in;
    @(posedge link_clk_out);
    run = 1'h0;
  endtask
endmodule

/* tb/test_digipot_command_decoder.sv */
// Purpose: self-checking bench of the dpc command decoder
// Assumes: host model owns the link clock; pins are driven here
// Notes: every reset costs a 3000-cycle reload, so resets are few
`timescale 1ns/10ps
module test_digipot_command_decoder
  import dpc_pkg::*;
;
  typedef struct packed {
    logic [15:0] word;
    logic [7:0] w0;
    logic [7:0] w1;
    logic [5:0] flags;
    logic lin;
    logic [7:0] rd;
  } dpc_row_t;

  logic clk_in = 1'h0;
  logic srst_in, link_srst_in, load_n, rst_n, independent_mode_pin;
  logic link_clk, cmd_valid, cmd_ready, read_valid, busy, got_rd, ok;
  dpc_word_t cmd_word;
  logic [7:0] read_data, rd;
  logic [5:0] fl;
  dpc_pot_t pot;
  dpc_row_t rows [38];
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  always #5 clk_in = ~clk_in;

  dpc_core DUT (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .link_clk_in(link_clk),
    .link_srst_in(link_srst_in),
    .cmd_word_in(cmd_word),
    .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready),
    .read_data_out(read_data),
    .read_valid_out(read_valid),
    .load_wiper_strobe_n_in(load_n),
    .reset_n_in(rst_n),
    .independent_mode_pin_in(independent_mode_pin),
    .pot_out(pot),
    .busy_out(busy)
  );

  dpc_host_model host (
    .link_srst_in(link_srst_in),
    .cmd_ready_in(cmd_ready),
    .read_data_in(read_data),
    .read_valid_in(read_valid),
    .link_clk_out(link_clk),
    .cmd_word_out(cmd_word),
    .cmd_valid_out(cmd_valid)
  );

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // four resets of 3000 cycles plus traffic stay well below this
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_idle(output int cnt);
    cnt = 0;
    while (busy !== 1'h0 && cnt < 4000) begin
      @(posedge clk_in);
      #1;
      cnt++;
    end
    check("idle", 16'(busy), 16'h0000);
  endtask

  task automatic cmd(input logic [15:0] w);
    host.send(w, rd, got_rd, ok);
    check("link ack", 16'(ok), 16'h0001);
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // pins pass a 3-flop filter, so pulses are held 5 cycles
  task automatic pulse_pin(input logic on_load);
    @(posedge clk_in);
    load_n <= ~on_load;
    rst_n <= on_load;
    repeat (5) @(posedge clk_in);
    load_n <= 1'h1;
    rst_n <= 1'h1;
    repeat (12) @(posedge clk_in);
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    srst_in <= 1'h1;
    link_srst_in <= 1'h1;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'h0;
    #1;
    check("busy after reset", 16'(busy), 16'h0001);
    repeat (12) @(posedge clk_in);
    link_srst_in <= 1'h0;
    wait_idle(n);
    check("reload time", 16'(n > 2900 && n < 3010), 16'h0001);
    check("lower after reset", 16'(pot.wiper[0]), 16'h0080);
    check("upper after reset", 16'(pot.wiper[1]), 16'h0080);
  endtask

  initial begin
    srst_in = 1'h1;
    link_srst_in = 1'h1;
    load_n = 1'h1;
    rst_n = 1'h1;
    independent_mode_pin = 1'h0;
    rows = '{
      {16'h105a,8'h5a,8'h80,6'h00,1'h0,8'h00}, {16'h00ff,8'h5a,8'h80,6'h00,1'h0,8'h00},
      {16'h3003,8'h5a,8'h80,6'h00,1'h0,8'h5a}, {16'h3000,8'h5a,8'h80,6'h00,1'h0,8'h5a},
      {16'h2011,8'h5a,8'h80,6'h00,1'h0,8'h00}, {16'h3000,8'h5a,8'h80,6'h00,1'h0,8'h11},
      {16'h6000,8'h11,8'h80,6'h00,1'h0,8'h00}, {16'h4001,8'h12,8'h80,6'h00,1'h0,8'h00},
      {16'h5001,8'h24,8'h80,6'h00,1'h0,8'h00}, {16'h5000,8'h12,8'h80,6'h00,1'h0,8'h00},
      {16'h4000,8'h11,8'h80,6'h00,1'h0,8'h00}, {16'h7001,8'h11,8'h80,6'h00,1'h0,8'h00},
      {16'h3001,8'h11,8'h80,6'h00,1'h0,8'h11}, {16'h3002,8'h11,8'h80,6'h00,1'h0,8'h03},
      {16'h82ab,8'h11,8'h80,6'h00,1'h0,8'h00}, {16'h3201,8'h11,8'h80,6'h00,1'h0,8'hab},
      {16'h9081,8'h11,8'h80,6'h04,1'h0,8'h00}, {16'h9080,8'h11,8'h80,6'h00,1'h0,8'h00},
      {16'h9001,8'h11,8'h80,6'h01,1'h0,8'h00}, {16'h9000,8'h11,8'h80,6'h00,1'h0,8'h00},
      {16'hc001,8'h11,8'h80,6'h10,1'h0,8'h00}, {16'hc000,8'h11,8'h80,6'h00,1'h0,8'h00},
      {16'hd007,8'h11,8'h80,6'h00,1'h1,8'h00}, {16'h14c4,8'h11,8'hc4,6'h00,1'h1,8'h00},
      {16'h4801,8'h12,8'hc5,6'h00,1'h1,8'h00}, {16'h2433,8'h12,8'hc5,6'h00,1'h1,8'h00},
      {16'h6800,8'h12,8'h33,6'h00,1'h1,8'h00}, {16'hd000,8'h12,8'h33,6'h00,1'h0,8'h00},
      {16'h1099,8'h12,8'h33,6'h00,1'h0,8'h00}, {16'h82cd,8'h12,8'h33,6'h00,1'h0,8'h00},
      {16'h3201,8'h12,8'h33,6'h00,1'h0,8'hab}, {16'h7000,8'h11,8'h33,6'h00,1'h0,8'h00},
      {16'hd003,8'h11,8'h33,6'h00,1'h0,8'h00}, {16'h14ee,8'h11,8'h33,6'h00,1'h0,8'h00},
      {16'h10ff,8'hff,8'h33,6'h00,1'h0,8'h00}, {16'h4001,8'hff,8'h33,6'h00,1'h0,8'h00},
      {16'h5001,8'hff,8'h33,6'h00,1'h0,8'h00}, {16'h5000,8'h7f,8'h33,6'h00,1'h0,8'h00}
    };
    do_reset();
    check("ctrl linear", 16'(pot.linear_mode_bit), 16'h0000);
    foreach (rows[i]) begin
      cmd(rows[i].word);
      fl = {pot.shutdown, pot.top_scale, pot.bottom_scale};
      check("lower wiper", 16'(pot.wiper[0]), 16'(rows[i].w0));
      check("upper wiper", 16'(pot.wiper[1]), 16'(rows[i].w1));
      check("flags", 16'(fl), 16'(rows[i].flags));
      check("linear mode", 16'(pot.linear_mode_bit), 16'(rows[i].lin));
      if (rows[i].word[15:12] == 4'h3) begin
        check("read valid", 16'(got_rd), 16'h0001);
        check("read data", 16'(rd), 16'(rows[i].rd));
      end
    end
    // staged value stays hidden until the pin falls
    cmd(16'h2044);
    check("staged only", 16'(pot.wiper[0]), 16'h007f);
    pulse_pin(1'h1);
    check("pin load", 16'(pot.wiper[0]), 16'h0044);
    cmd(16'hd00b);
    check("burst on", 16'(pot.burst), 16'h0001);
    // a pin edge during the software reset reload must be lost
    cmd(16'h2055);
    fork
      cmd(16'hb000);
      begin
        n = 0;
        while (busy !== 1'h1 && n < 400) begin
          @(posedge clk_in);
          n++;
        end
        pulse_pin(1'h1);
      end
    join
    wait_idle(n);
    check("sw reset reload", 16'(pot.wiper[0]), 16'h0011);
    check("burst cleared", 16'(pot.burst), 16'h0000);
    cmd(16'h1022);
    pulse_pin(1'h0);
    check("pin reset busy", 16'(busy), 16'h0001);
    wait_idle(n);
    check("pin reload time", 16'(n > 2900 && n < 3010), 16'h0001);
    check("pin reset reload", 16'(pot.wiper[0]), 16'h0011);
    @(posedge clk_in);
    independent_mode_pin <= 1'h1;
    do_reset();
    check("pin forces linear", 16'(pot.linear_mode_bit), 16'h0001);
    cmd(16'hd003);
    cmd(16'h145d);
    check("mode is an or", 16'(pot.linear_mode_bit), 16'h0001);
    check("upper reachable", 16'(pot.wiper[1]), 16'h005d);
    test_done();
  end
endmodule
